/* File: design/spindle_protect_pkg.sv */
// Package with codes, encodings and carriers for the spindle protection manager
package spindle_protect_pkg;

    // ----------------------------------------
    // Display code encodings
    // ----------------------------------------
    localparam logic [7:0] CODE_NONE       = 8'h00;
    localparam logic [7:0] CODE_A0_CORD    = 8'hA0;
    localparam logic [7:0] CODE_A1_LOW_AIR = 8'hA1;
    localparam logic [7:0] CODE_A2_HOT     = 8'hA2;
    localparam logic [7:0] CODE_A3_LOAD    = 8'hA3;
    localparam logic [7:0] CODE_A4_ESTOP   = 8'hA4;
    localparam logic [7:0] CODE_A5_HI_AIR  = 8'hA5;

    // ----------------------------------------
    // Widths and timing
    // ----------------------------------------
    localparam int          WARN_COUNT       = 6;
    localparam int          ERR_COUNT        = 16;
    localparam int          CLK_PERIOD_PS    = 5000;
    localparam int          BLINK_HALF_MS    = 250;
    localparam int          BLINK_HALF_CYC   = BLINK_HALF_MS * 1000 / 5 * 1000;
    localparam int          BLINK_W          = 26;
    localparam logic [3:0]  ERR_IDX_ESTOP    = 4'hC;
    localparam logic [7:0]  ERR_CODE_BASE    = 8'hE0;

    // Error output mode select
    typedef enum logic [1:0] {
        ERR_MODE_LEVEL_HI = 2'b00,
        ERR_MODE_LEVEL_LO = 2'b01,
        ERR_MODE_CODE     = 2'b10
    } err_mode_t;

    // Release sequence states for automatic mode
    typedef enum logic [1:0] {
        REL_IDLE   = 2'b00,
        REL_OPEN   = 2'b01,
        REL_CLOSED = 2'b10
    } rel_state_t;

    // Indications toward panel and cabinet
    typedef struct packed {
        logic       warn_lamp;
        logic       err_lamp;
        logic [7:0] display_code;
        logic       warn_contact;
        logic       err_signal;
    } indication_t;

endpackage : spindle_protect_pkg

/* File: design/pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync
    import spindle_protect_pkg::*;
#(
    parameter logic RESET_LEVEL = 1'b0
) (
    input  wire logic clock_in,
    input  wire logic rst_n_in,
    input  wire logic pin_in,
    output logic      level_out
);
    logic stage_a;
    logic stage_b;
    logic stage_c;
    logic level;
    logic next_level;

    // ----------------------------------------
    // Filter: change only when stages two and three agree
    // ----------------------------------------
    always_comb begin
        next_level = level;
        if (stage_b == stage_c) begin
            next_level = stage_c;
        end
    end

    // Registers
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stage_a <= RESET_LEVEL;
            stage_b <= RESET_LEVEL;
            stage_c <= RESET_LEVEL;
            level   <= RESET_LEVEL;
        end else begin
            stage_a <= pin_in;
            stage_b <= stage_a;
            stage_c <= stage_b;
            level   <= next_level;
        end
    end

    assign level_out = level;
endmodule : pin_sync
`default_nettype wire

/* File: design/spindle_fault_protection_manager.sv */
// Spindle protection and fault manager: e-stop, warnings, latched errors
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/1ps
`default_nettype none
module spindle_fault_protection_manager
    import spindle_protect_pkg::*;
#(
    parameter int BLINK_CYCLES = BLINK_HALF_CYC
) (
    input  wire logic                  clock_in,
    input  wire logic                  rst_n_in,
    input  wire logic                  estop_loop_input_in,  // High = loop closed
    input  wire logic                  estop_mode_in,        // E-stop as warning mode
    input  wire logic                  relay_weld_in,        // NO contact welded
    input  wire logic [WARN_COUNT-1:0] warn_cond_in,         // Bit n gives code An
    input  wire logic [ERR_COUNT-1:0]  err_cond_in,          // Error sources
    input  wire logic                  auto_mode_in,         // High = automatic mode
    input  wire logic                  panel_reset_in,       // Panel reset button
    input  wire logic                  release_in,           // High = release closed
    input  wire err_mode_t             err_mode_in,
    output logic                       safety_relay_on_out,
    output logic                       motor_enable_out,
    output logic                       safety_contact_one_a_out,
    output logic                       safety_contact_one_b_out,
    output logic                       safety_contact_two_a_out,
    output logic                       safety_contact_two_b_out,
    output logic                       auto_contact_out,
    output indication_t                ind_out
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic estop_closed;
    logic button;
    logic release_closed;

    pin_sync #(.RESET_LEVEL(1'b0)) u_sync_estop (
        .clock_in (clock_in),
        .rst_n_in (rst_n_in),
        .pin_in   (estop_loop_input_in),
        .level_out(estop_closed)
    );
    pin_sync #(.RESET_LEVEL(1'b0)) u_sync_button (
        .clock_in (clock_in),
        .rst_n_in (rst_n_in),
        .pin_in   (panel_reset_in),
        .level_out(button)
    );
    pin_sync #(.RESET_LEVEL(1'b0)) u_sync_release (
        .clock_in (clock_in),
        .rst_n_in (rst_n_in),
        .pin_in   (release_in),
        .level_out(release_closed)
    );

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic                  err_latched;
    logic [3:0]            err_index;
    logic                  button_prev;
    rel_state_t            rel_state;
    logic [BLINK_W-1:0]    blink_cnt;
    logic                  blink;
    logic                  relay_on;
    logic                  motor_en;
    logic                  nc_one;
    logic                  nc_two;
    logic                  auto_contact;
    indication_t           ind;

    logic                  next_err_latched;
    logic [3:0]            next_err_index;
    rel_state_t            next_rel_state;
    logic [BLINK_W-1:0]    next_blink_cnt;
    logic                  next_blink;
    logic                  next_relay_on;
    logic                  next_motor_en;
    logic                  next_nc;
    indication_t           next_ind;

    logic                  estop_err;
    logic                  any_err;
    logic [3:0]            first_err;
    logic                  release_ok;
    logic [7:0]            warn_code;
    logic                  any_warn;
    logic [WARN_COUNT-1:0] warns;

    // ----------------------------------------
    // Fault sources and priority
    // ----------------------------------------
    always_comb begin
        // Open loop outside warning mode is an error, inside it a warning
        estop_err = !estop_closed && !estop_mode_in;
        warns     = warn_cond_in;
        warns[4]  = warn_cond_in[4] | (!estop_closed && estop_mode_in);
        any_err   = estop_err || (err_cond_in != '0);
        first_err = ERR_IDX_ESTOP;
        for (int i = ERR_COUNT - 1; i >= 0; i--) begin
            if (err_cond_in[i]) begin
                first_err = 4'(i);
            end
        end
        any_warn  = (warns != '0);
        warn_code = CODE_NONE;
        for (int j = WARN_COUNT - 1; j >= 0; j--) begin
            if (warns[j]) begin
                warn_code = CODE_A0_CORD + 8'(j);
            end
        end
    end

    // ----------------------------------------
    // Release sequence and error latch
    // ----------------------------------------
    always_comb begin
        next_rel_state = rel_state;
        release_ok     = 1'b0;
        unique case (rel_state)
            REL_IDLE:   if (!release_closed) begin
                next_rel_state = REL_OPEN;
            end
            REL_OPEN:   if (release_closed) begin
                next_rel_state = REL_CLOSED;
            end
            REL_CLOSED: if (!release_closed) begin
                next_rel_state = REL_OPEN;
                release_ok     = auto_mode_in;
            end
            default:    next_rel_state = REL_IDLE;
        endcase
        if (!auto_mode_in && button && !button_prev) begin
            release_ok = 1'b1;
        end
        next_err_latched = err_latched;
        next_err_index   = err_index;
        if (release_ok) begin
            next_err_latched = 1'b0;
        end
        // A standing fault wins over the release
        if (any_err && (!err_latched || release_ok)) begin
            next_err_latched = 1'b1;
            next_err_index   = first_err;
        end
    end

    // ----------------------------------------
    // Blink timer, relay, motor, indications
    // ----------------------------------------
    always_comb begin
        next_blink_cnt = blink_cnt + BLINK_W'(1);
        next_blink     = blink;
        if (blink_cnt >= BLINK_W'(BLINK_CYCLES - 1)) begin
            next_blink_cnt = '0;
            next_blink     = !blink;
        end
        next_relay_on = estop_closed && !estop_err;
        next_motor_en = next_relay_on && !next_err_latched;
        // NC contacts closed when relay is off; weld keeps them open
        next_nc = !next_relay_on && !relay_weld_in;
        next_ind.warn_lamp    = any_warn && blink;
        next_ind.warn_contact = any_warn;
        next_ind.err_lamp     = next_err_latched;
        if (next_err_latched) begin
            next_ind.display_code = ERR_CODE_BASE + {4'h0, next_err_index};
        end else begin
            next_ind.display_code = warn_code;
        end
        unique case (err_mode_in)
            ERR_MODE_LEVEL_HI: next_ind.err_signal = next_err_latched;
            ERR_MODE_LEVEL_LO: next_ind.err_signal = !next_err_latched;
            ERR_MODE_CODE:     next_ind.err_signal = next_err_latched || (any_warn && blink);
            default:           next_ind.err_signal = next_err_latched;
        endcase
    end

    // Registers
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            err_latched  <= 1'b0;
            err_index    <= 4'h0;
            button_prev  <= 1'b0;
            rel_state    <= REL_IDLE;
            blink_cnt    <= '0;
            blink        <= 1'b0;
            relay_on     <= 1'b0;
            motor_en     <= 1'b0;
            nc_one       <= 1'b0;
            nc_two       <= 1'b0;
            auto_contact <= 1'b0;
            ind          <= '0;
        end else begin
            err_latched  <= next_err_latched;
            err_index    <= next_err_index;
            button_prev  <= button;
            rel_state    <= next_rel_state;
            blink_cnt    <= next_blink_cnt;
            blink        <= next_blink;
            relay_on     <= next_relay_on;
            motor_en     <= next_motor_en;
            nc_one       <= next_nc;
            nc_two       <= next_nc;
            auto_contact <= auto_mode_in;
            ind          <= next_ind;
        end
    end

    // Output drive
    assign safety_relay_on_out      = relay_on;
    assign motor_enable_out         = motor_en;
    assign safety_contact_one_a_out = nc_one;
    assign safety_contact_one_b_out = nc_one;
    assign safety_contact_two_a_out = nc_two;
    assign safety_contact_two_b_out = nc_two;
    assign auto_contact_out         = auto_contact;
    assign ind_out                  = ind;
endmodule : spindle_fault_protection_manager
`default_nettype wire

/* File: test/cabinet_model.sv */
// Cabinet model: e-stop loop and error release contact
`timescale 1ns/1ps
`default_nettype none
module cabinet_model (
    input  wire logic clock_in,
    input  wire logic loop_closed_in,
    input  wire logic release_req_in,
    output logic      estop_pin_out,
    output logic      release_pin_out,
    output logic      busy_out
);
    logic [4:0] step_cnt;
    initial begin
        step_cnt = 5'h00;
        estop_pin_out = 1'b1;
        release_pin_out = 1'b0;
    end
    // Loop closed for running, opened to ask for a stop
    always @(posedge clock_in) estop_pin_out <= #1 loop_closed_in;
    // Release contact open, closed, open; no rotate command held
    always @(posedge clock_in) begin
        if (step_cnt == 5'h00) step_cnt <= #1 {4'h0, release_req_in};
        else step_cnt <= #1 step_cnt + 5'h01;
        release_pin_out <= #1 (step_cnt > 5'h00) && (step_cnt < 5'h0B);
    end
    assign busy_out = (step_cnt != 5'h00) || release_req_in;
endmodule : cabinet_model
`default_nettype wire

/* File: test/spindle_fault_protection_manager_sva.sv */
// Checker for the spindle protection manager ports
`timescale 1ns/1ps
`default_nettype none
module spindle_fault_protection_manager_sva
    import spindle_protect_pkg::*;
(
    input wire logic                  clock_in,
    input wire logic                  rst_n_in,
    input wire logic                  estop_loop_input_in,
    input wire logic                  relay_weld_in,
    input wire logic [WARN_COUNT-1:0] warn_cond_in,
    input wire logic [ERR_COUNT-1:0]  err_cond_in,
    input wire logic                  auto_mode_in,
    input wire logic                  panel_reset_in,
    input wire logic                  release_in,
    input wire err_mode_t             err_mode_in,
    input wire logic                  safety_relay_on_out,
    input wire logic                  motor_enable_out,
    input wire logic                  safety_contact_one_b_out,
    input wire logic                  auto_contact_out,
    input wire indication_t           ind_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    logic [3:0] quiet;
    logic [3:0] next_quiet;
    // Cycles since the last release action
    always_comb begin
        next_quiet = (quiet == 4'hF) ? quiet : quiet + 4'h1;
        if (panel_reset_in || release_in) next_quiet = 4'h0;
    end
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) quiet <= 4'h0;
        else quiet <= next_quiet;
    end
    a_estop_relay_off: assert property ((!estop_loop_input_in)[*6] |->
        !safety_relay_on_out && !motor_enable_out) else $error("relay on with loop open");
    a_relay_opens_nc: assert property (!relay_weld_in ##1 !safety_relay_on_out
        |-> safety_contact_one_b_out) else $error("contact open with relay off");
    a_weld_holds_open: assert property (relay_weld_in[*2] |-> !safety_contact_one_b_out)
        else $error("contact closed with weld");
    a_error_stops_motor: assert property (ind_out.err_lamp |-> !motor_enable_out)
        else $error("motor enabled in error");
    a_err_high_level: assert property (ind_out.err_lamp && err_mode_in == ERR_MODE_LEVEL_HI
        && $past(err_mode_in) == ERR_MODE_LEVEL_HI |-> ind_out.err_signal) else $error("level hi");
    a_err_low_level: assert property (ind_out.err_lamp && err_mode_in == ERR_MODE_LEVEL_LO
        && $past(err_mode_in) == ERR_MODE_LEVEL_LO |-> !ind_out.err_signal) else $error("level lo");
    a_warn_contact_on: assert property ((warn_cond_in != 6'h00)[*2] |-> ind_out.warn_contact)
        else $error("warning contact open");
    a_lamp_needs_warn: assert property (ind_out.warn_lamp |-> ind_out.warn_contact)
        else $error("warning lamp without warning");
    a_code_mode_blink: assert property (!ind_out.err_lamp && err_mode_in == ERR_MODE_CODE
        && $past(err_mode_in) == ERR_MODE_CODE |-> ind_out.err_signal == ind_out.warn_lamp)
        else $error("code mode output does not follow lamp");
    a_warn_code_shown: assert property ((warn_cond_in == 6'h04)[*2] ##0 !ind_out.err_lamp
        |-> ind_out.display_code == CODE_A2_HOT) else $error("warning code");
    a_err_code_shown: assert property ((err_cond_in == 16'h0008)[*2] |->
        ind_out.err_lamp && ind_out.display_code == 8'hE3) else $error("error code");
    a_error_stays_latched: assert property ($fell(ind_out.err_lamp) |-> quiet < 4'hC)
        else $error("error cleared without release");
    a_auto_contact_on: assert property (auto_mode_in[*2] |-> auto_contact_out)
        else $error("auto contact open");
    c_err_cleared: cover property ($fell(ind_out.err_lamp));
    c_weld_seen: cover property (relay_weld_in && !safety_relay_on_out);
    c_warn_seen: cover property ($rose(ind_out.warn_contact));
endmodule : spindle_fault_protection_manager_sva
bind spindle_fault_protection_manager spindle_fault_protection_manager_sva i_sva (
    .clock_in, .rst_n_in, .estop_loop_input_in, .relay_weld_in, .warn_cond_in, .err_cond_in,
    .auto_mode_in, .panel_reset_in, .release_in, .err_mode_in, .safety_relay_on_out,
    .motor_enable_out, .safety_contact_one_b_out, .auto_contact_out, .ind_out);
`default_nettype wire

/* File: test/spindle_fault_protection_manager_test.sv */
// Self-checking bench for the spindle protection manager
`timescale 1ns/1ps
`default_nettype none
module spindle_fault_protection_manager_test
    import spindle_protect_pkg::*;
;
    logic        clock_in = 1'b0, rst_n_in = 1'b0, loop_cmd = 1'b1, rel_cmd = 1'b0;
    logic        estop_mode = 1'b0, weld = 1'b0, auto_mode = 1'b0, panel = 1'b0, watch = 1'b0;
    logic        busy, estop_pin, rel_pin, relay, motor, c1a, c1b, c2a, c2b, auto_c, lamp_last;
    logic [5:0]  warn = 6'h00;
    logic [15:0] err = 16'h0000;
    err_mode_t   mode = ERR_MODE_LEVEL_HI;
    indication_t ind;
    logic [11:0] obs, last, q[$];
    int          mismatches = 0, comparisons = 0, seed = 42720, idx, lamp_edges = 0;
    always #2.5 clock_in = ~clock_in;
    spindle_fault_protection_manager #(.BLINK_CYCLES(4)) i_spindle_fault_protection_manager (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .estop_loop_input_in(estop_pin),
        .estop_mode_in(estop_mode), .relay_weld_in(weld), .warn_cond_in(warn),
        .err_cond_in(err), .auto_mode_in(auto_mode), .panel_reset_in(panel),
        .release_in(rel_pin), .err_mode_in(mode), .safety_relay_on_out(relay),
        .motor_enable_out(motor), .safety_contact_one_a_out(c1a), .safety_contact_one_b_out(c1b),
        .safety_contact_two_a_out(c2a), .safety_contact_two_b_out(c2b),
        .auto_contact_out(auto_c), .ind_out(ind));
    cabinet_model i_cabinet_model (.clock_in(clock_in), .loop_closed_in(loop_cmd),
        .release_req_in(rel_cmd), .estop_pin_out(estop_pin), .release_pin_out(rel_pin),
        .busy_out(busy));
    assign obs = {ind.err_lamp, ind.display_code, ind.warn_contact, ind.err_signal, motor};
    task automatic chk(input logic [11:0] exp, input logic [11:0] got);
        comparisons++;
        if (exp !== got) begin
            mismatches++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk
    task automatic test_done;
        if (q.size() != 0) mismatches++;
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done
    // Expected view: error lamp, code, warning contact, error level, motor
    function automatic logic [11:0] ex(input logic e, input logic [7:0] c, input logic w);
        return {e, c, w, (mode == ERR_MODE_LEVEL_LO) ? !e : e, !e};
    endfunction : ex
    task automatic step(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask : step
    task automatic press;
        panel = 1'b1;
        step(4);
        panel = 1'b0;
        step(12);
    endtask : press
    task automatic rel;
        rel_cmd = 1'b1;
        step(1);
        rel_cmd = 1'b0;
        step(1);
        for (int k = 0; k < 60 && busy; k++) step(1);
        if (busy) begin
            mismatches++;
            test_done;
        end
        step(12);
    endtask : rel
    // Output watcher: each change takes the oldest note
    always @(posedge clock_in) begin
        #2;
        if (watch && obs !== last) chk(q.size() ? q.pop_front() : 12'hXXX, obs);
        last = obs;
        if (ind.warn_lamp !== lamp_last) lamp_edges++;
        lamp_last = ind.warn_lamp;
    end
    initial begin
        #100000;
        mismatches++;
        test_done;
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clock_in);
        #1 rst_n_in = 1'b1;
        step(10);
        press;
        watch = 1'b1;
        for (int n = 0; n < 6; n++) begin
            warn = 6'h01 << n;
            q.push_back(ex(1'b0, 8'(CODE_A0_CORD + n), 1'b1));
            step(12);
            warn = 6'h00;
            q.push_back(ex(1'b0, CODE_NONE, 1'b0));
            step(12);
        end
        chk(12'h001, {11'h000, lamp_edges > 4});
        auto_mode = 1'b1;
        step(4);
        chk(12'h001, {11'h000, auto_c});
        err = 16'h0008;
        q.push_back(ex(1'b1, 8'hE3, 1'b0));
        step(12);
        err = 16'h0000;
        press;
        q.push_back(ex(1'b0, CODE_NONE, 1'b0));
        rel;
        auto_mode = 1'b0;
        mode = ERR_MODE_LEVEL_LO;
        q.push_back(ex(1'b0, CODE_NONE, 1'b0));
        step(12);
        idx = {$random(seed)} % 12;
        err = 16'h0001 << idx;
        q.push_back(ex(1'b1, 8'(8'hE0 + idx), 1'b0));
        step(12);
        err = 16'h0000;
        rel;
        q.push_back(ex(1'b0, CODE_NONE, 1'b0));
        press;
        estop_mode = 1'b1;
        loop_cmd = 1'b0;
        q.push_back(ex(1'b0, CODE_A4_ESTOP, 1'b1) & 12'hFFE);
        step(12);
        loop_cmd = 1'b1;
        q.push_back(ex(1'b0, CODE_NONE, 1'b0));
        step(12);
        estop_mode = 1'b0;
        loop_cmd = 1'b0;
        q.push_back(ex(1'b1, 8'hEC, 1'b0));
        step(12);
        chk(12'h00F, {7'h00, relay, c1a, c1b, c2a, c2b});
        weld = 1'b1;
        step(8);
        chk(12'h000, {7'h00, relay, c1a, c1b, c2a, c2b});
        weld = 1'b0;
        loop_cmd = 1'b1;
        step(12);
        q.push_back(ex(1'b0, CODE_NONE, 1'b0));
        press;
        chk(12'h010, {7'h00, relay, c1a, c1b, c2a, c2b});
        mode = ERR_MODE_CODE;
        q.push_back(ex(1'b0, CODE_NONE, 1'b0));
        step(12);
        err = 16'h0002;
        q.push_back(ex(1'b1, 8'(ERR_CODE_BASE + 8'h01), 1'b0));
        step(12);
        err = 16'h0000;
        warn = 6'h08;
        q.push_back(ex(1'b1, 8'(ERR_CODE_BASE + 8'h01), 1'b1));
        step(12);
        // Lamp and error output blink together here; checked by the checker
        watch = 1'b0;
        press;
        warn = 6'h00;
        step(12);
        watch = 1'b1;
        chk(ex(1'b0, CODE_NONE, 1'b0), obs);
        test_done;
    end
endmodule : spindle_fault_protection_manager_test
`default_nettype wire
